/* hw/eltc_regs.sv */
// eltc_regs: low-power-idle timer configuration registers and timers
`timescale 1ns/100ps
module eltc_regs #(
	parameter int RXQ_UNIT = eltc_pkg::RXQ_STEP_CYC, // cycles per quiet-limit step
	parameter int FLD_UNIT = eltc_pkg::FLD_STEP_CYC  // cycles per 5 ms drop step
) (
	input  wire logic        clock,              // 50 MHz
	input  wire logic        rst_n,              // synchronous, active low
	input  wire logic [7:0]  address,            // byte address
	input  wire logic        read,               // avalon read
	input  wire logic        write,              // avalon write
	input  wire logic [31:0] writedata,          // avalon write data
	input  wire logic [3:0]  byteenable,         // avalon lanes
	output logic      [31:0] readdata,           // avalon read data
	output logic             waitrequest,        // avalon stall
	output logic             irq,                // level interrupt
	input  wire logic        gig_wake_start,     // gigabit wake entered
	output logic             gig_wake_done,      // gigabit wake timer expired
	input  wire logic        tx_quiet_start,     // quiet period begins
	output logic             tx_quiet_done,      // quiet period over, pulse
	input  wire logic        rx_enter_sleep,     // receiver entered Sleep
	input  wire logic        rx_enter_quiet,     // receiver entered Quiet
	input  wire logic        rx_enter_wake,      // receiver entered Wake
	input  wire logic        rx_enter_idle,      // receiver entered Idle
	input  wire logic        rx_sleep_idle_seen, // valid sleep or idle symbols
	input  wire logic        rx_idle_sym,        // idle symbol this cycle
	output logic             rx_idle_ok,         // idle run long enough
	input  wire logic        snr_good,           // snr above floor
	output logic             snr_ok,             // snr good long enough
	input  wire logic        link_lost,          // raw link-loss indication
	output logic             link_down,          // fast link down declared
	output logic             link_fail,          // link failure, pulse
	output logic             rx_active           // receiver active indication
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {RX_ACTIVE, RX_SLEEP, RX_QUIET, RX_WAKE, RX_IDLE} eltc_rx_type;
	typedef struct packed {
		logic [31:0]                      rd;       // read data
		logic                             wr;       // waitrequest
		logic                             irq;      // interrupt
		logic [15:0]                      gig_wake_timer;
		logic [15:0]                      fast_wake_snr_timer;
		logic [15:0]                      quiet_period_count;
		logic [15:0]                      low_power_control_two;
		logic [15:0]                      fast_rx_timer_limits;
		logic [15:0]                      fast_link_fail_control;
		logic [15:0]                      err_count; // wake error counter
		logic [3:0]                       status;   // sticky events
		logic [3:0]                       mask;     // event enables
		eltc_rx_type                      rxs;      // receiver state
		logic [eltc_pkg::NT-1:0][23:0]    cnt;      // timer counts
		logic [eltc_pkg::NT-1:0]          run;      // timer running
		logic                             gig_done;
		logic                             txq_done;
		logic                             idle_ok;
		logic                             snr_ok;
		logic                             drop;     // link down level
		logic                             fail;     // link failure pulse
		logic                             rx_act;
		logic                             prev_idle;
		logic                             prev_snr;
		logic                             prev_lost;
	} eltc_state_type;

	eltc_state_type s;      // registered state
	eltc_state_type next_s; // next state

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// threshold times step, never below one cycle
	function automatic logic [23:0] tload(input logic [15:0] thr, input int unit);
		logic [31:0] p;
		p = 32'(thr) * 32'(unit);
		return (p == 32'h0) ? 24'h000001 : p[23:0];
	endfunction

	// merge the low two byte lanes into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	// drop delay: code 0 none, else 5 ms doubling per code
	function automatic logic [23:0] drop_load(input logic [2:0] code);
		logic [31:0] p;
		p = 32'(FLD_UNIT) << (code - 3'h1);
		return p[23:0];
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// one combinational pass: timers, receiver tracking, bus, events
	always_comb begin
		logic [eltc_pkg::NT-1:0] fire;
		logic [3:0]              ev;
		logic [3:0]              clr;
		logic [23:0]             gl;
		logic [1:0]              inc;
		logic                    take;
		fire = '0;
		ev = '0;
		clr = '0;
		gl = '0;
		inc = '0;
		take = 1'b0;
		next_s = s;
		next_s.fail = 1'b0;
		next_s.txq_done = 1'b0;
		// count every running timer down, flag expiry
		for (int i = 0; i < eltc_pkg::NT; i++) begin
			if (s.run[i]) begin
				if (s.cnt[i] == 24'h000001) begin
					fire[i] = 1'b1;
					next_s.run[i] = 1'b0;
				end else begin
					next_s.cnt[i] = s.cnt[i] - 24'h000001;
				end
			end
		end
		// gigabit wake timer, capped
		gl = tload(s.gig_wake_timer, eltc_pkg::GIG_STEP_CYC);
		if (gl > 24'(eltc_pkg::GIG_MAX_CYC)) begin
			gl = 24'(eltc_pkg::GIG_MAX_CYC);
		end
		if (gig_wake_start) begin
			next_s.gig_done = 1'b0;
			next_s.run[eltc_pkg::T_GIG] = 1'b1;
			next_s.cnt[eltc_pkg::T_GIG] = gl;
		end else if (fire[eltc_pkg::T_GIG]) begin
			next_s.gig_done = 1'b1;
			ev[eltc_pkg::EV_GIG] = 1'b1;
		end
		// transmit quiet period, count times 2048 ns
		if (tx_quiet_start) begin
			next_s.run[eltc_pkg::T_TXQ] = 1'b1;
			next_s.cnt[eltc_pkg::T_TXQ] = tload(s.quiet_period_count, eltc_pkg::QUIET_STEP_CYC);
		end else if (fire[eltc_pkg::T_TXQ]) begin
			next_s.txq_done = 1'b1;
		end
		// receiver state entries restart or stop the state timers
		if (rx_enter_sleep) begin
			next_s.rxs = RX_SLEEP;
			next_s.run[eltc_pkg::T_SLP] = 1'b1;
			next_s.cnt[eltc_pkg::T_SLP] = tload({8'h00, s.fast_rx_timer_limits[7:0]},
				eltc_pkg::SLEEP_STEP_CYC);
			next_s.run[eltc_pkg::T_RXQ] = 1'b0;
			next_s.run[eltc_pkg::T_LF] = 1'b0;
		end else if (rx_enter_quiet) begin
			next_s.rxs = RX_QUIET;
			next_s.run[eltc_pkg::T_RXQ] = 1'b1;
			next_s.cnt[eltc_pkg::T_RXQ] = tload({12'h000, s.fast_rx_timer_limits[11:8]}, RXQ_UNIT);
			next_s.run[eltc_pkg::T_SLP] = 1'b0;
			next_s.run[eltc_pkg::T_LF] = 1'b0;
		end else if (rx_enter_wake) begin
			next_s.rxs = RX_WAKE;
			next_s.run[eltc_pkg::T_LF] = 1'b1;
			next_s.cnt[eltc_pkg::T_LF] = tload({11'h000, s.fast_link_fail_control[12:8]},
				eltc_pkg::LF_STEP_CYC);
			next_s.run[eltc_pkg::T_RXW] = 1'b1;
			next_s.cnt[eltc_pkg::T_RXW] = tload({10'h000, s.fast_link_fail_control[5:0]},
				eltc_pkg::RXW_STEP_CYC);
			next_s.run[eltc_pkg::T_SLP] = 1'b0;
			next_s.run[eltc_pkg::T_RXQ] = 1'b0;
		end else if (rx_enter_idle) begin
			next_s.rxs = RX_IDLE;
			next_s.run[eltc_pkg::T_LF] = 1'b0;
			next_s.run[eltc_pkg::T_SLP] = 1'b0;
			next_s.run[eltc_pkg::T_RXQ] = 1'b0;
		end
		// valid sleep or idle symbols end the receive wake window
		if (rx_sleep_idle_seen && !rx_enter_wake) begin
			next_s.run[eltc_pkg::T_RXW] = 1'b0;
		end
		// link failure from quiet, sleep or wake limits
		if (fire[eltc_pkg::T_RXQ] || fire[eltc_pkg::T_SLP] || fire[eltc_pkg::T_LF]) begin
			next_s.fail = 1'b1;
			next_s.rxs = RX_ACTIVE;
			ev[eltc_pkg::EV_FAIL] = 1'b1;
		end
		// receive wake error
		if (fire[eltc_pkg::T_RXW]) begin
			ev[eltc_pkg::EV_WAKEERR] = 1'b1;
		end
		// wake error counter, one step per source
		inc = {1'b0, ev[eltc_pkg::EV_GIG]} + {1'b0, ev[eltc_pkg::EV_WAKEERR]};
		next_s.err_count = s.err_count + {14'h0000, inc};
		// consecutive idle symbols
		next_s.prev_idle = rx_idle_sym;
		if (!rx_idle_sym) begin
			next_s.idle_ok = 1'b0;
			next_s.run[eltc_pkg::T_IDLE] = 1'b0;
		end else if (!s.prev_idle) begin
			next_s.run[eltc_pkg::T_IDLE] = 1'b1;
			next_s.cnt[eltc_pkg::T_IDLE] = tload({12'h000, s.fast_rx_timer_limits[15:12]},
				eltc_pkg::IDLE_STEP_CYC);
		end else if (fire[eltc_pkg::T_IDLE]) begin
			next_s.idle_ok = 1'b1;
		end
		// snr must stay good for the threshold
		next_s.prev_snr = snr_good;
		if (!snr_good) begin
			next_s.snr_ok = 1'b0;
			next_s.run[eltc_pkg::T_SNR] = 1'b0;
		end else if (!s.prev_snr) begin
			next_s.run[eltc_pkg::T_SNR] = 1'b1;
			next_s.cnt[eltc_pkg::T_SNR] = tload(s.fast_wake_snr_timer, 1);
		end else if (fire[eltc_pkg::T_SNR]) begin
			next_s.snr_ok = 1'b1;
		end
		// fast link down with bypass and delay code
		next_s.prev_lost = link_lost;
		if (!link_lost) begin
			next_s.drop = 1'b0;
			next_s.run[eltc_pkg::T_FLD] = 1'b0;
		end else if (!s.prev_lost && !s.low_power_control_two[eltc_pkg::SKIP_BIT]) begin
			if (s.fast_link_fail_control[15:13] == 3'h0) begin
				next_s.drop = 1'b1;
				ev[eltc_pkg::EV_DROP] = 1'b1;
			end else begin
				next_s.run[eltc_pkg::T_FLD] = 1'b1;
				next_s.cnt[eltc_pkg::T_FLD] = drop_load(s.fast_link_fail_control[15:13]);
			end
		end else if (fire[eltc_pkg::T_FLD]) begin
			next_s.drop = 1'b1;
			ev[eltc_pkg::EV_DROP] = 1'b1;
		end
		// receive-active indication outside Sleep and Quiet
		next_s.rx_act = s.fast_link_fail_control[eltc_pkg::RXACT_BIT] &&
			(next_s.rxs != RX_SLEEP) && (next_s.rxs != RX_QUIET);
		// bus: one wait state, then the access completes
		if ((read || write) && s.wr) begin
			next_s.wr = 1'b0;
			if (read) begin
				next_s.rd = 32'h00000000;
				if (address[7:2] == eltc_pkg::IDX_GIG_WAKE) begin
					next_s.rd[15:0] = s.gig_wake_timer;
				end else if (address[7:2] == eltc_pkg::IDX_SNR) begin
					next_s.rd[15:0] = s.fast_wake_snr_timer;
				end else if (address[7:2] == eltc_pkg::IDX_QUIET) begin
					next_s.rd[15:0] = s.quiet_period_count;
				end else if (address[7:2] == eltc_pkg::IDX_CTRL_TWO) begin
					next_s.rd[15:0] = s.low_power_control_two;
				end else if (address[7:2] == eltc_pkg::IDX_RX_LIMITS) begin
					next_s.rd[15:0] = s.fast_rx_timer_limits;
				end else if (address[7:2] == eltc_pkg::IDX_LF_CTRL) begin
					next_s.rd[15:0] = s.fast_link_fail_control;
				end else if (address[7:2] == eltc_pkg::IDX_ERR_COUNT) begin
					next_s.rd[15:0] = s.err_count;
				end else if (address[7:2] == eltc_pkg::IDX_STATUS) begin
					next_s.rd[3:0] = s.status;
				end else if (address[7:2] == eltc_pkg::IDX_MASK) begin
					next_s.rd[3:0] = s.mask;
				end
			end
		end else begin
			next_s.wr = 1'b1;
			take = write && !s.wr;
		end
		// register writes land at the completing edge
		if (take) begin
			if (address[7:2] == eltc_pkg::IDX_GIG_WAKE) begin
				next_s.gig_wake_timer = merge(s.gig_wake_timer, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_SNR) begin
				next_s.fast_wake_snr_timer = merge(s.fast_wake_snr_timer, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_QUIET) begin
				next_s.quiet_period_count = merge(s.quiet_period_count, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_CTRL_TWO) begin
				next_s.low_power_control_two = merge(s.low_power_control_two, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_RX_LIMITS) begin
				next_s.fast_rx_timer_limits = merge(s.fast_rx_timer_limits, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_LF_CTRL) begin
				next_s.fast_link_fail_control = merge(s.fast_link_fail_control, writedata, byteenable);
			end else if (address[7:2] == eltc_pkg::IDX_STATUS) begin
				clr = byteenable[0] ? writedata[3:0] : 4'h0;
			end else if (address[7:2] == eltc_pkg::IDX_MASK) begin
				next_s.mask = byteenable[0] ? writedata[3:0] : s.mask;
			end
		end
		// sticky events: a new event beats a clear in the same cycle
		next_s.status = (s.status & ~clr) | ev;
		next_s.irq = |(next_s.status & next_s.mask);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// single clocked process, synchronous reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
			s.wr <= 1'b1;
			s.gig_wake_timer <= eltc_pkg::RST_GIG_WAKE;
			s.fast_wake_snr_timer <= eltc_pkg::RST_SNR;
			s.quiet_period_count <= eltc_pkg::RST_QUIET;
			s.low_power_control_two <= eltc_pkg::RST_CTRL_TWO;
			s.fast_rx_timer_limits <= eltc_pkg::RST_RX_LIMITS;
			s.fast_link_fail_control <= eltc_pkg::RST_LF_CTRL;
		end else begin
			s <= next_s;
		end
	end

	assign readdata = s.rd;
	assign waitrequest = s.wr;
	assign irq = s.irq;
	assign gig_wake_done = s.gig_done;
	assign tx_quiet_done = s.txq_done;
	assign rx_idle_ok = s.idle_ok;
	assign snr_ok = s.snr_ok;
	assign link_down = s.drop;
	assign link_fail = s.fail;
	assign rx_active = s.rx_act;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence q_lost_rise;
		link_lost && !s.prev_lost;
	endsequence
	sequence q_wake_armed;
		s.run[eltc_pkg::T_RXW] && (s.cnt[eltc_pkg::T_RXW] == 24'h000001);
	endsequence

	property p_gig_load;
		@(posedge clock) disable iff (!rst_n)
		gig_wake_start |=> s.run[eltc_pkg::T_GIG] && !s.gig_done &&
			(s.cnt[eltc_pkg::T_GIG] <= 24'(eltc_pkg::GIG_MAX_CYC));
	endproperty
	a_gig_load: assert property (p_gig_load) else $error("gig wake timer not loaded");

	logic fire_rxw; // helper for the counter check
	assign fire_rxw = s.run[eltc_pkg::T_RXW] && (s.cnt[eltc_pkg::T_RXW] == 24'h000001);

	property p_gig_count;
		@(posedge clock) disable iff (!rst_n)
		$rose(s.gig_done) |-> s.err_count == $past(s.err_count) + 16'h0001 + 16'($past(fire_rxw));
	endproperty
	a_gig_count: assert property (p_gig_count) else $error("wake done not counted");

	property p_quiet_load;
		@(posedge clock) disable iff (!rst_n)
		tx_quiet_start |=> s.cnt[eltc_pkg::T_TXQ] == tload($past(s.quiet_period_count),
			eltc_pkg::QUIET_STEP_CYC);
	endproperty
	a_quiet_load: assert property (p_quiet_load) else $error("quiet period wrong");

	property p_skip;
		@(posedge clock) disable iff (!rst_n)
		q_lost_rise and s.low_power_control_two[eltc_pkg::SKIP_BIT] |=> !s.drop [*2];
	endproperty
	a_skip: assert property (p_skip) else $error("link down despite bypass");

	property p_drop_zero;
		@(posedge clock) disable iff (!rst_n)
		q_lost_rise and !s.low_power_control_two[eltc_pkg::SKIP_BIT] &&
			(s.fast_link_fail_control[15:13] == 3'h0) |=> s.drop && s.status[eltc_pkg::EV_DROP];
	endproperty
	a_drop_zero: assert property (p_drop_zero) else $error("zero delay drop late");

	property p_idle;
		@(posedge clock) disable iff (!rst_n)
		$rose(s.idle_ok) |-> $past(rx_idle_sym, 1) && $past(rx_idle_sym, 2);
	endproperty
	a_idle: assert property (p_idle) else $error("idle ok without idle run");

	property p_snr;
		@(posedge clock) disable iff (!rst_n)
		$rose(s.snr_ok) |-> $past(snr_good, 1) && $past(snr_good, 2);
	endproperty
	a_snr: assert property (p_snr) else $error("snr ok without good snr");

	property p_fail_src;
		@(posedge clock) disable iff (!rst_n)
		s.fail |-> $past(s.rxs) inside {RX_QUIET, RX_SLEEP, RX_WAKE};
	endproperty
	a_fail_src: assert property (p_fail_src) else $error("link failure from wrong state");

	property p_sleep_fail;
		@(posedge clock) disable iff (!rst_n)
		s.run[eltc_pkg::T_SLP] && (s.cnt[eltc_pkg::T_SLP] == 24'h000001) |=> s.fail;
	endproperty
	a_sleep_fail: assert property (p_sleep_fail) else $error("sleep limit missed");

	property p_wake_fail;
		@(posedge clock) disable iff (!rst_n)
		rx_enter_wake |=> s.run[eltc_pkg::T_LF] && (s.cnt[eltc_pkg::T_LF] ==
			tload({11'h000, $past(s.fast_link_fail_control[12:8])}, eltc_pkg::LF_STEP_CYC));
	endproperty
	a_wake_fail: assert property (p_wake_fail) else $error("link fail timer not armed");

	property p_rxwake;
		@(posedge clock) disable iff (!rst_n)
		q_wake_armed |=> s.status[eltc_pkg::EV_WAKEERR] && (s.err_count != $past(s.err_count));
	endproperty
	a_rxwake: assert property (p_rxwake) else $error("receive wake error missed");

	property p_rxact;
		@(posedge clock) disable iff (!rst_n)
		s.rx_act |-> $past(s.fast_link_fail_control[eltc_pkg::RXACT_BIT]);
	endproperty
	a_rxact: assert property (p_rxact) else $error("rx active while disabled");
endmodule

/* common/eltc_pkg.sv */
// eltc_pkg: register map, reset values and timer step constants
package eltc_pkg;
	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_GIG_WAKE  = 6'h2D; // gig_wake_timer
	localparam logic [5:0] IDX_SNR       = 6'h2E; // fast_wake_snr_timer
	localparam logic [5:0] IDX_QUIET     = 6'h30; // quiet_period_count
	localparam logic [5:0] IDX_CTRL_TWO  = 6'h34; // low_power_control_two
	localparam logic [5:0] IDX_RX_LIMITS = 6'h36; // fast_rx_timer_limits
	localparam logic [5:0] IDX_LF_CTRL   = 6'h37; // fast_link_fail_control
	localparam logic [5:0] IDX_ERR_COUNT = 6'h3A; // wake error counter, read only
	localparam logic [5:0] IDX_STATUS    = 6'h3B; // sticky events, write one to clear
	localparam logic [5:0] IDX_MASK      = 6'h3C; // interrupt enables
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] RST_GIG_WAKE  = 16'h0080;
	localparam logic [15:0] RST_SNR       = 16'h0370;
	localparam logic [15:0] RST_QUIET     = 16'h29F5;
	localparam logic [15:0] RST_CTRL_TWO  = 16'h8000;
	localparam logic [15:0] RST_RX_LIMITS = 16'h677A;
	localparam logic [15:0] RST_LF_CTRL   = 16'h3514;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SKIP_BIT   = 15; // skip_quick_drop
	localparam int RXACT_BIT  = 6;  // receive-active enable
	localparam int EV_GIG     = 0;  // gigabit wake done
	localparam int EV_FAIL    = 1;  // 100 Mb/s link failure
	localparam int EV_WAKEERR = 2;  // 100 Mb/s receive wake error
	localparam int EV_DROP    = 3;  // fast link down
	// ------------------------------------------------------------
	// timer slots and time base
	// ------------------------------------------------------------
	localparam int NT = 9;
	localparam int T_GIG = 0, T_TXQ = 1, T_RXQ = 2, T_SLP = 3, T_LF = 4;
	localparam int T_RXW = 5, T_FLD = 6, T_IDLE = 7, T_SNR = 8;
	localparam int CLK_NS         = 20;
	localparam int GIG_STEP_NS    = 128;
	localparam int GIG_MAX_NS     = 16500;
	localparam int QUIET_STEP_NS  = 2048;
	localparam int IDLE_STEP_NS   = 140;
	localparam int RXQ_STEP_NS    = 3500000;
	localparam int SLEEP_STEP_NS  = 2000;
	localparam int LF_STEP_NS     = 4800;
	localparam int RXW_STEP_NS    = 1000;
	localparam int FLD_STEP_NS    = 5000000;
	localparam int GIG_STEP_CYC   = GIG_STEP_NS / CLK_NS;
	localparam int GIG_MAX_CYC    = GIG_MAX_NS / CLK_NS;
	localparam int QUIET_STEP_CYC = QUIET_STEP_NS / CLK_NS;
	localparam int IDLE_STEP_CYC  = (IDLE_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RXQ_STEP_CYC   = RXQ_STEP_NS / CLK_NS;
	localparam int SLEEP_STEP_CYC = SLEEP_STEP_NS / CLK_NS;
	localparam int LF_STEP_CYC    = LF_STEP_NS / CLK_NS;
	localparam int RXW_STEP_CYC   = RXW_STEP_NS / CLK_NS;
	localparam int FLD_STEP_CYC   = FLD_STEP_NS / CLK_NS;
endpackage

/* bench/eltc_partner.sv */
// eltc_partner: link partner model giving idle symbols, snr and loss
`timescale 1ns/100ps
module eltc_partner (
	input  wire logic clock,
	input  wire logic drop,
	input  wire logic idles,
	output logic      idle_sym = 1'b0,
	output logic      snr_good = 1'b1,
	output logic      lost     = 1'b0
);
	// idle symbols are random each cycle unless idles holds them high; snr and loss follow the cable
	always @(posedge clock) begin
		idle_sym <= idles | 1'($urandom);
		snr_good <= ~drop;
		lost     <= drop;
	end
endmodule

/* bench/testbench.sv */
// testbench: register, timer and event checks of the lpi timer bank
`timescale 1ns/100ps
module testbench;
	logic clock = 0, rst_n = 0, read = 0, write = 0, drop = 0, gws = 0, sls = 0;
	logic tqs = 0, wks = 0, idles = 0;
	logic [7:0]  address    = 0;
	logic [31:0] writedata  = 0;
	logic [3:0]  byteenable = 0;
	logic [31:0] readdata, rd, v;
	logic waitrequest, irq, gwd, tqd, rxok, snrok, ldown, lfail, rxact, isym, sg, lost;
	int failures = 0, n_tests = 0, cycles = 0, errs = 0, n, thr, ex;
	logic [5:0]  idx [6] = '{eltc_pkg::IDX_GIG_WAKE, eltc_pkg::IDX_SNR, eltc_pkg::IDX_QUIET,
		eltc_pkg::IDX_CTRL_TWO, eltc_pkg::IDX_RX_LIMITS, eltc_pkg::IDX_LF_CTRL};
	logic [15:0] rv [6] = '{eltc_pkg::RST_GIG_WAKE, eltc_pkg::RST_SNR, eltc_pkg::RST_QUIET,
		eltc_pkg::RST_CTRL_TWO, eltc_pkg::RST_RX_LIMITS, eltc_pkg::RST_LF_CTRL};
	eltc_regs #(.RXQ_UNIT(10), .FLD_UNIT(20)) i_dut (.clock(clock), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.gig_wake_start(gws), .gig_wake_done(gwd), .tx_quiet_start(tqs), .tx_quiet_done(tqd),
		.rx_enter_sleep(sls), .rx_enter_quiet(1'b0), .rx_enter_wake(wks), .rx_enter_idle(1'b0),
		.rx_sleep_idle_seen(1'b0), .rx_idle_sym(isym), .rx_idle_ok(rxok), .snr_good(sg),
		.snr_ok(snrok), .link_lost(lost), .link_down(ldown), .link_fail(lfail), .rx_active(rxact));
	eltc_partner i_partner (.clock(clock), .drop(drop), .idles(idles), .idle_sym(isym), .snr_good(sg),
		.lost(lost));
	// clock and cycle ceiling
	initial forever #10 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures = failures + 1;
			stop_test();
		end
	end
	// compare and count
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one avalon access, held until waitrequest is sampled low
	task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clock);
		read <= ~wr;
		write <= wr;
		address <= {a, 2'b00};
		writedata <= d;
		byteenable <= 4'hF;
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// cycles from the start edge until the chosen output rises
	task wait_out(input int sel);
		n = 1;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while ((sel == 2 ? tqd : sel == 1 ? lfail : gwd) !== 1'b1 && n < 2000);
	endtask
	initial begin
		n = $urandom(32'h823B1C9A);
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			bus(0, idx[i], 0);
			check("reset value", rd, {16'h0, rv[i]});
		end
		bus(0, 6'h3F, 0);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			bus(1, idx[i], v);
			bus(0, idx[i], 0);
			check("readback", rd, {16'h0, v[15:0]});
		end
		$display("register test done");
		// gigabit wake, threshold changed between starts
		for (int k = 0; k < 2; k++) begin
			thr = 1 + $urandom % 200;
			ex = thr * eltc_pkg::GIG_STEP_CYC;
			if (ex > eltc_pkg::GIG_MAX_CYC)
				ex = eltc_pkg::GIG_MAX_CYC;
			bus(1, eltc_pkg::IDX_GIG_WAKE, thr);
			@(posedge clock);
			gws <= 1'b1;
			@(posedge clock);
			gws <= 1'b0;
			wait_out(0);
			errs++;
			check("wake time", n, ex + 1);
			bus(0, eltc_pkg::IDX_ERR_COUNT, 0);
			check("wake errors", rd, errs);
		end
		$display("wake test done");
		// sleep limit of one step, then interrupt raise, mask and clear
		bus(1, eltc_pkg::IDX_RX_LIMITS, 32'h1701);
		@(posedge clock);
		sls <= 1'b1;
		@(posedge clock);
		sls <= 1'b0;
		wait_out(1);
		check("sleep limit", n, eltc_pkg::SLEEP_STEP_CYC + 1);
		bus(0, eltc_pkg::IDX_STATUS, 0);
		check("status", rd, 32'h3);
		bus(1, eltc_pkg::IDX_MASK, 32'h2);
		repeat (2) @(posedge clock);
		check("irq set", irq, 1'b1);
		bus(1, eltc_pkg::IDX_STATUS, 32'h2);
		repeat (2) @(posedge clock);
		check("irq clear", irq, 1'b0);
		// a steady idle line passes the one-step idle limit
		idles <= 1'b1;
		repeat (12) @(posedge clock);
		check("idle run", rxok, 1'b1);
		idles <= 1'b0;
		$display("event test done");
		// wake: receive wake limit 1, link-fail limit 1, rx active on, drop code 0
		bus(1, eltc_pkg::IDX_LF_CTRL, 32'h0141);
		repeat (2) @(posedge clock);
		check("rx active", rxact, 1'b1);
		wks <= 1'b1;
		@(posedge clock);
		wks <= 1'b0;
		wait_out(1);
		errs++;
		check("link fail time", n, eltc_pkg::LF_STEP_CYC + 1);
		bus(0, eltc_pkg::IDX_ERR_COUNT, 0);
		check("rx wake errors", rd, errs);
		bus(0, eltc_pkg::IDX_STATUS, 0);
		check("wake status", rd, 32'h7);
		// quiet period of one step
		bus(1, eltc_pkg::IDX_QUIET, 32'h1);
		@(posedge clock);
		tqs <= 1'b1;
		@(posedge clock);
		tqs <= 1'b0;
		wait_out(2);
		check("quiet time", n, eltc_pkg::QUIET_STEP_CYC + 1);
		$display("link test done");
		// fast link down bypassed, then code zero; snr threshold of five cycles
		bus(1, eltc_pkg::IDX_CTRL_TWO, 32'h8000);
		bus(1, eltc_pkg::IDX_SNR, 32'h5);
		drop <= 1'b1;
		repeat (5) @(posedge clock);
		check("drop bypassed", ldown, 1'b0);
		check("snr lost", snrok, 1'b0);
		drop <= 1'b0;
		bus(1, eltc_pkg::IDX_CTRL_TWO, 32'h0);
		drop <= 1'b1;
		repeat (3) @(posedge clock);
		check("drop code 0", ldown, 1'b1);
		drop <= 1'b0;
		repeat (7) @(posedge clock);
		check("snr early", snrok, 1'b0);
		@(posedge clock);
		check("snr ok", snrok, 1'b1);
		$display("drop test done");
		stop_test();
	end
endmodule
